// [dmie_pkg.sv]
// Constants and types for the data-move instruction execution block
package dmie_pkg;

  // Instruction, data, address and bank widths, pointer count and select field width
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int PTR_COUNT = 3;
  localparam int PTR_SEL_W = 2;

  // Opcode patterns, compared against the top bits of a word
  localparam logic [9:0] OP_PTR_LOAD = 10'h3B8;
  localparam logic [5:0] OP_MOVE_REG = 6'h14;
  localparam logic [3:0] OP_MOVE_R2R = 4'hC;
  localparam logic [3:0] OP_SECOND_WORD = 4'hF;

  // Field positions
  localparam int OPC4_HI = 15;
  localparam int OPC4_LO = 12;
  localparam int OPC6_LO = 10;
  localparam int OPC10_LO = 6;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int PSEL_HI = 5;
  localparam int PSEL_LO = 4;
  localparam int KHI_HI = 3;
  localparam int KHI_LO = 0;
  localparam int PTR_HI_LO = 8;

  // Fixed access bank: low half maps to bank 0, high half to the top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // Reset values
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  // Four-phase instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } dmie_phase_t;

  // Which second word is awaited
  typedef enum logic [2:0] {
    PD_NONE = 3'h1,
    PD_PTR = 3'h2,
    PD_DEST = 3'h4
  } dmie_pend_t;

  // Operation being executed in the current instruction cycle
  typedef enum logic [5:0] {
    EX_NONE = 6'h01,
    EX_MOVE_REG = 6'h02,
    EX_R2R_SRC = 6'h04,
    EX_R2R_DST = 6'h08,
    EX_PTR_HI = 6'h10,
    EX_PTR_LO = 6'h20
  } dmie_exec_t;

endpackage

// [dmie_core.sv]
// Execution logic for pointer load, register move and register-to-register move
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns

// What this block does
// [RULE_01] The pointer-load instruction writes its 12-bit literal into the pointer register its select field names.
// [RULE_02] The register move sends the value to the accumulator when the destination bit is 0, back to the register when 1.
// [RULE_03] With the bank-access bit 0 the register move uses the fixed access bank, with 1 the bank select register.
// [RULE_04] The register move takes an 8-bit address selecting any byte of the chosen 256-byte bank.
// [RULE_05] The register-to-register move is two words, opcode 1100 with source then prefix 1111 with destination.
// [RULE_06] The register-to-register move copies source to destination, source untouched, flags untouched.
// [RULE_07] The register-to-register source address is a full 12-bit flat address with no bank selection.
// [RULE_08] The register move updates negative and zero flags; the other two moves leave all flags alone.
module dmie_core #(
  parameter int NUM_PTRS = dmie_pkg::PTR_COUNT
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [3:0] i_bank_sel,
  input wire logic [7:0] i_mem_rdata,
  output logic [3:0] o_phase,
  output logic o_second_pending,
  output logic [11:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  output logic o_acc_we,
  output logic [7:0] o_acc_wdata,
  output logic o_flag_we,
  output logic o_flag_n,
  output logic o_flag_z,
  output logic [11:0] o_ptr0,
  output logic [11:0] o_ptr1,
  output logic [11:0] o_ptr2
);

  dmie_pkg::dmie_phase_t ph_r;
  dmie_pkg::dmie_pend_t pend_r;
  dmie_pkg::dmie_pend_t pend_nxt;
  dmie_pkg::dmie_exec_t ex_r;
  dmie_pkg::dmie_exec_t ex_nxt;
  logic [15:0] ir_r;
  logic [1:0] psel_r;
  logic [7:0] data_r;
  logic [11:0] addr_nxt;
  logic [11:0] ptr_r [NUM_PTRS];
  logic [3:0] opc4;
  logic [5:0] opc6;
  logic [9:0] opc10;
  logic [7:0] reg_off;
  logic [11:0] bank_addr;
  logic take;
  logic in_q3;
  logic in_q4;
  logic is_second;
  logic is_r2r;
  logic is_move;
  logic is_ptr;
  logic rd_nxt;
  logic to_acc;
  logic to_reg;
  logic move_n;
  logic move_z;
  logic psel_ok;
  logic ptr_hi_we;
  logic ptr_lo_we;
  logic src_held_r;

  // The three pointer ports and the 2-bit select field fix the pointer count
  if (NUM_PTRS != dmie_pkg::PTR_COUNT) begin : g_bad_ptr_count
    $error("dmie_core serves exactly three pointer registers");
  end
  // Port widths must agree with the package field widths
  if ($bits(o_mem_addr) != dmie_pkg::ADDR_W || $bits(i_mem_rdata) != dmie_pkg::DATA_W) begin : g_bad_data_width
    $error("dmie_core memory port widths disagree with the package");
  end
  if ($bits(i_instr) != dmie_pkg::INSTR_W || $bits(i_bank_sel) != dmie_pkg::BANK_W) begin : g_bad_instr_width
    $error("dmie_core instruction port widths disagree with the package");
  end

  assign opc4 = i_instr[dmie_pkg::OPC4_HI:dmie_pkg::OPC4_LO];
  assign opc6 = i_instr[dmie_pkg::OPC4_HI:dmie_pkg::OPC6_LO];
  assign opc10 = i_instr[dmie_pkg::OPC4_HI:dmie_pkg::OPC10_LO];
  assign reg_off = i_instr[7:0];
  assign take = (ph_r == dmie_pkg::PH_Q1) && i_instr_valid;

  // Phase markers for the process and write slots
  assign in_q3 = (ph_r == dmie_pkg::PH_Q3);
  assign in_q4 = (ph_r == dmie_pkg::PH_Q4);

  // Opcode classes of the offered word; the second-word prefix is tested first
  assign is_second = (opc4 == dmie_pkg::OP_SECOND_WORD);
  assign is_r2r = (opc4 == dmie_pkg::OP_MOVE_R2R);
  assign is_move = (opc6 == dmie_pkg::OP_MOVE_REG);
  assign is_ptr = (opc10 == dmie_pkg::OP_PTR_LOAD);

  // Only the register move and the first copy word read; the second copy word does no dummy read
  assign rd_nxt = (ex_nxt == dmie_pkg::EX_MOVE_REG) || (ex_nxt == dmie_pkg::EX_R2R_SRC);

  // Destination of a register move, chosen by the latched destination bit
  assign to_acc = (ex_r == dmie_pkg::EX_MOVE_REG) && !ir_r[dmie_pkg::DEST_BIT];
  assign to_reg = (ex_r == dmie_pkg::EX_MOVE_REG) && ir_r[dmie_pkg::DEST_BIT];

  // Negative and zero of the byte that stands on the read data in Q3
  assign move_n = i_mem_rdata[dmie_pkg::DATA_W - 1];
  assign move_z = (i_mem_rdata == dmie_pkg::DATA_RESET);

  // Banked address of a register move
  always_comb begin
    if (!i_instr[dmie_pkg::BANK_BIT]) begin
      if (reg_off < dmie_pkg::ACCESS_SPLIT) begin
        bank_addr = {dmie_pkg::ACCESS_LO_BANK, reg_off}; // [RULE_03] [RULE_04]
      end else begin
        bank_addr = {dmie_pkg::ACCESS_HI_BANK, reg_off}; // [RULE_03] [RULE_04]
      end
    end else begin
      bank_addr = {i_bank_sel, reg_off}; // [RULE_03] [RULE_04]
    end
  end

  // Decode of the word offered in Q1
  always_comb begin
    ex_nxt = dmie_pkg::EX_NONE;
    pend_nxt = dmie_pkg::PD_NONE;
    addr_nxt = o_mem_addr;
    if (is_second) begin
      // A second word with nothing pending executes as no operation
      if (pend_r == dmie_pkg::PD_DEST) begin
        ex_nxt = dmie_pkg::EX_R2R_DST; // [RULE_05]
        addr_nxt = i_instr[11:0];
      end else if (pend_r == dmie_pkg::PD_PTR) begin
        ex_nxt = dmie_pkg::EX_PTR_LO; // [RULE_01]
      end else begin
        ex_nxt = dmie_pkg::EX_NONE;
      end
    end else if (is_r2r) begin
      ex_nxt = dmie_pkg::EX_R2R_SRC; // [RULE_05]
      pend_nxt = dmie_pkg::PD_DEST;
      addr_nxt = i_instr[11:0]; // [RULE_07]
    end else if (is_move) begin
      ex_nxt = dmie_pkg::EX_MOVE_REG;
      addr_nxt = bank_addr;
    end else if (is_ptr) begin
      ex_nxt = dmie_pkg::EX_PTR_HI; // [RULE_01]
      pend_nxt = dmie_pkg::PD_PTR;
    end else begin
      ex_nxt = dmie_pkg::EX_NONE;
    end
  end

  // Four-phase sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ph_r <= dmie_pkg::PH_Q1;
    end else begin
      case (ph_r)
        dmie_pkg::PH_Q1: ph_r <= dmie_pkg::PH_Q2;
        dmie_pkg::PH_Q2: ph_r <= dmie_pkg::PH_Q3;
        dmie_pkg::PH_Q3: ph_r <= dmie_pkg::PH_Q4;
        dmie_pkg::PH_Q4: ph_r <= dmie_pkg::PH_Q1;
        default: ph_r <= dmie_pkg::PH_Q1;
      endcase
    end
  end

  // Instruction latch and two-word tracking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ex_r <= dmie_pkg::EX_NONE;
      pend_r <= dmie_pkg::PD_NONE;
      ir_r <= dmie_pkg::INSTR_RESET;
      psel_r <= '0;
    end else if (ph_r == dmie_pkg::PH_Q1) begin
      if (i_instr_valid) begin
        ex_r <= ex_nxt;
        pend_r <= pend_nxt;
        ir_r <= i_instr;
        if (ex_nxt == dmie_pkg::EX_PTR_HI) begin
          psel_r <= i_instr[dmie_pkg::PSEL_HI:dmie_pkg::PSEL_LO]; // [RULE_01]
        end
      end else begin
        ex_r <= dmie_pkg::EX_NONE;
      end
    end
  end

  // Data memory address and read strobe, read in Q2
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_addr <= dmie_pkg::ADDR_RESET;
      o_mem_rd <= 1'b0;
    end else if (take) begin
      o_mem_addr <= addr_nxt;
      o_mem_rd <= rd_nxt;
    end else begin
      o_mem_rd <= 1'b0;
    end
  end

  // Source byte of a register-to-register move, held until the second word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_r <= dmie_pkg::DATA_RESET;
    end else if (in_q3 && (ex_r == dmie_pkg::EX_R2R_SRC)) begin
      data_r <= i_mem_rdata; // [RULE_06]
    end
  end

  // A copy writes only a source byte that a first word really read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_held_r <= 1'b0;
    end else if (in_q3 && (ex_r == dmie_pkg::EX_R2R_SRC)) begin
      src_held_r <= 1'b1;
    end else if (in_q4 && (ex_r == dmie_pkg::EX_R2R_DST)) begin
      src_held_r <= 1'b0;
    end
  end

  // Memory write, issued for Q4
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_wr <= 1'b0;
      o_mem_wdata <= dmie_pkg::DATA_RESET;
    end else if (in_q3) begin
      if (to_reg) begin
        o_mem_wr <= 1'b1; // [RULE_02]
        o_mem_wdata <= i_mem_rdata;
      end else if ((ex_r == dmie_pkg::EX_R2R_DST) && src_held_r) begin
        o_mem_wr <= 1'b1; // [RULE_06]
        o_mem_wdata <= data_r;
      end else begin
        o_mem_wr <= 1'b0;
      end
    end else begin
      o_mem_wr <= 1'b0;
    end
  end

  // Accumulator write, issued for Q4
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_acc_we <= 1'b0;
      o_acc_wdata <= dmie_pkg::DATA_RESET;
    end else if (in_q3 && to_acc) begin
      o_acc_we <= 1'b1; // [RULE_02]
      o_acc_wdata <= i_mem_rdata;
    end else begin
      o_acc_we <= 1'b0;
    end
  end

  // Status flags: only the register move touches them
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flag_we <= 1'b0;
      o_flag_n <= 1'b0;
      o_flag_z <= 1'b0;
    end else if (in_q3 && (ex_r == dmie_pkg::EX_MOVE_REG)) begin
      o_flag_we <= 1'b1; // [RULE_08]
      o_flag_n <= move_n;
      o_flag_z <= move_z;
    end else begin
      o_flag_we <= 1'b0;
    end
  end

  // Pointer writes land in Q4; a select of 3 names no pointer and writes nothing
  assign psel_ok = (psel_r < 2'(NUM_PTRS));
  assign ptr_hi_we = in_q4 && (ex_r == dmie_pkg::EX_PTR_HI) && psel_ok; // [RULE_01]
  assign ptr_lo_we = in_q4 && (ex_r == dmie_pkg::EX_PTR_LO) && psel_ok; // [RULE_01]

  // Indirect pointers, high nibble on the first word, low byte on the second
  for (genvar g = 0; g < NUM_PTRS; g++) begin : g_ptr
    localparam logic [1:0] PTR_ID = 2'(g);
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        ptr_r[g] <= dmie_pkg::PTR_RESET;
      end else if (ptr_hi_we && (psel_r == PTR_ID)) begin
        ptr_r[g][11:dmie_pkg::PTR_HI_LO] <= ir_r[dmie_pkg::KHI_HI:dmie_pkg::KHI_LO]; // [RULE_01]
      end else if (ptr_lo_we && (psel_r == PTR_ID)) begin
        ptr_r[g][7:0] <= ir_r[7:0]; // [RULE_01]
      end
    end
  end

  // Pending flag kept as its own register so the port comes straight from a flop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_second_pending <= 1'b0;
    end else if (take) begin
      o_second_pending <= (pend_nxt != dmie_pkg::PD_NONE); // [RULE_05]
    end
  end

  assign o_phase = ph_r;
  assign o_ptr0 = ptr_r[0];
  assign o_ptr1 = ptr_r[1];
  assign o_ptr2 = ptr_r[2];

endmodule

// [dmie_core_properties.sv]
// Concurrent checks on the ports of the data-move execution block
`timescale 1ns/1ns
module dmie_core_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [3:0] i_bank_sel,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [3:0] o_phase,
  input wire logic o_second_pending,
  input wire logic [11:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_acc_we,
  input wire logic [7:0] o_acc_wdata,
  input wire logic o_flag_we,
  input wire logic o_flag_n,
  input wire logic o_flag_z,
  input wire logic [11:0] o_ptr0,
  input wire logic [11:0] o_ptr1,
  input wire logic [11:0] o_ptr2
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic tk = (o_phase == 4'h1) && i_instr_valid;
  wire logic mv = tk && (i_instr[15:10] == 6'h14);
  sequence s_mv_walk;
    o_mem_rd ##2 (o_flag_we && o_phase == 4'h8);
  endsequence
  a_mv_walk: assert property (mv |=> s_mv_walk)
    else $error("register move steps out of order");
  a_mv_offset: assert property (mv |=> o_mem_addr[7:0] == $past(i_instr[7:0]))
    else $error("register move offset wrong");
  a_bank_reg: assert property (mv && i_instr[8] |=> o_mem_addr[11:8] == $past(i_bank_sel))
    else $error("bank select not used");
  a_access_bank: assert property (mv && !i_instr[8] |=> o_mem_addr[11:8] == ($past(i_instr[7]) ? 4'hF : 4'h0))
    else $error("access bank mapping wrong");
  a_acc_dest: assert property (mv && !i_instr[9] |-> ##3 (o_acc_we && !o_mem_wr))
    else $error("accumulator not loaded");
  a_reg_dest: assert property (mv && i_instr[9] |-> ##3 (o_mem_wr && !o_acc_we))
    else $error("register not written back");
  a_r2r_src: assert property (tk && i_instr[15:12] == 4'hC |=> o_mem_rd && o_mem_addr == $past(i_instr[11:0]))
    else $error("flat source address wrong");
  a_acc_flags: assert property (o_acc_we |-> o_flag_we && o_flag_n == o_acc_wdata[7] && o_flag_z == (o_acc_wdata == 8'h00))
    else $error("flags disagree with accumulator value");
  a_wr_flags: assert property (o_flag_we && o_mem_wr |-> o_flag_n == o_mem_wdata[7] && o_flag_z == (o_mem_wdata == 8'h00))
    else $error("flags disagree with written value");
  a_flags_hold: assert property ($changed(o_flag_n) || $changed(o_flag_z) |-> o_flag_we)
    else $error("flags changed without update strobe");
endmodule
bind dmie_core dmie_core_properties u_props (.*);

// [dmie_data_mem.sv]
// Behavioural data memory answering the execution block
`timescale 1ns/1ns
module dmie_data_mem (
  input wire logic i_clk,
  input wire logic [11:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [4096];
  initial o_rdata = 8'h00;
  // Read data valid only in the cycle after the strobe; scrambled otherwise
  always @(posedge i_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    if (i_rd) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
  end
endmodule

// [tb_top.sv]
// Directed testbench for the data-move execution block
`timescale 1ns/1ns
module tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0, pend, rd, wr, awe, fwe, fn, fz;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0] i_bank_sel = 4'h0, ph;
  logic [7:0] rdata, wd, ad, acc_seen, wr_seen, v;
  logic [11:0] addr, p0, p1, p2, a;
  int err_total = 0, n_checks = 0, cyc = 0;
  dmie_core u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
    .i_bank_sel(i_bank_sel), .i_mem_rdata(rdata), .o_phase(ph), .o_second_pending(pend), .o_mem_addr(addr),
    .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_wdata(wd), .o_acc_we(awe), .o_acc_wdata(ad), .o_flag_we(fwe),
    .o_flag_n(fn), .o_flag_z(fz), .o_ptr0(p0), .o_ptr1(p1), .o_ptr2(p2));
  dmie_data_mem u_mem (.i_clk(i_clk), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wd), .o_rdata(rdata));
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (awe) acc_seen <= ad;
    if (wr) wr_seen <= wd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One whole instruction cycle, starting just after the edge that begins Q1
  task automatic ex(input logic [15:0] w);
    i_instr <= w;
    i_instr_valid <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  logic [11:0] mv_addr [4] = '{12'h022, 12'hF90, 12'h510, 12'hAFF};
  logic [7:0] mv_val [4] = '{8'h00, 8'h80, 8'h7F, 8'hC3};
  logic [9:0] mv_op [4] = '{10'h022, 10'h090, 10'h110, 10'h3FF};
  initial begin
    for (int k = 0; k < 4; k++) u_mem.mem[mv_addr[k]] = mv_val[k];
    u_mem.mem[12'hABC] = 8'h33;
    u_mem.mem[12'h123] = 8'h11;
    u_mem.mem[12'h456] = 8'h55;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      a = 12'h3A0 + 12'(s);
      ex({8'hEE, 2'b00, 2'(s), a[11:8]});
      chk("pending", 12'h001, {11'h000, pend});
      ex({8'hF0, a[7:0]});
    end
    chk("ptr0", 12'h3A0, p0);
    chk("ptr1", 12'h3A1, p1);
    chk("ptr2", 12'h3A2, p2);
    $display("test pointer load done");
    i_bank_sel <= 4'hA;
    for (int k = 0; k < 4; k++) begin
      if (k == 2) i_bank_sel <= 4'h5;
      if (k == 3) i_bank_sel <= 4'hA;
      ex({6'h14, mv_op[k]});
      chk("move addr", mv_addr[k], addr);
      chk("move value", {4'h0, mv_val[k]}, {4'h0, (k == 3) ? wr_seen : acc_seen});
      chk("flag n", {11'h000, mv_val[k][7]}, {11'h000, fn});
      chk("flag z", {11'h000, mv_val[k] == 8'h00}, {11'h000, fz});
    end
    $display("test register move done");
    v = {fn, fz, 6'h00};
    ex(16'hCABC);
    ex(16'hF123);
    chk("r2r dest", 12'h033, {4'h0, u_mem.mem[12'h123]});
    chk("r2r src", 12'h033, {4'h0, u_mem.mem[12'hABC]});
    chk("r2r flags", {4'h0, v}, {4'h0, fn, fz, 6'h00});
    ex(16'hF456);
    chk("lone second", 12'h055, {4'h0, u_mem.mem[12'h456]});
    $display("test register copy done");
    give_verdict();
  end
endmodule
